// ==== logic/cdf_consts.vh ====
/*
 Constants for the complex decimation filter chain: modes, widths, stage
 scale shifts and half-band tap counts.
 Assumes inclusion by the design file and the bench; holds definitions only.
*/
// Functional notes
// RULE1: Every stage filters separate I and Q paths; outputs carry 15 bits each.
// RULE2: Each stage is a linear-phase FIR with symmetric taps.
// RULE3: Bypass passes real 12-bit samples at full clock rate, unfiltered.
// RULE4: Settings 4, 8, 16, 32 give complex 15-bit output at clock over factor.
// RULE5: Usable alias-free bandwidth is 0.8 of output rate in decimating modes.
// RULE6: Composite response: over 90 dB stop-band, ripple within 0.001 dB.
// RULE7: Each stage halves the rate and applies its own power-of-two scale.
// RULE8: Factor 4 runs fourth then last; factor 8 runs third, fourth, last.
// RULE9: Factor 16 runs second, third, fourth, then last stage.
// RULE10: Factor 32 runs first, second, third, fourth, then last stage.
// RULE11: Tap sets mirror about one centre tap; half plus centre multiply.
// RULE12: First stage taps -1,0,9,16,9,0,-1, scaled by 2^-5.
// RULE13: Second stage taps -65,0,577,1024,577,0,-65, scaled by 2^-11.
// RULE14: Third stage taps 109,0,-837,0,4824,8192 mirrored, scaled by 2^-14.
// RULE15: Fourth stage fifteen taps up to centre 65536, scaled by 2^-17.
// RULE16: Last stage taps start -37,0,118,... to centre, scaled by 2^-19.
// RULE17: I and Q use identical independent cascades, aligned at every stage.
// RULE18: Each stage rounds and saturates after shifting; final output 15 bits.
`ifndef CDF_CONSTS_VH
`define CDF_CONSTS_VH

`define CDF_MODE_BYP   3'h0
`define CDF_MODE_D4    3'h1
`define CDF_MODE_D8    3'h2
`define CDF_MODE_D16   3'h3
`define CDF_MODE_D32   3'h4
`define CDF_NO_STAGE   3'h5
`define CDF_LAST_STAGE 4
`define CDF_NSTAGE     5

`define CDF_CPLX_W     15
`define CDF_REAL_W     12
`define CDF_ACC_W      48

`define CDF_SH0        5
`define CDF_SH1        11
`define CDF_SH2        14
`define CDF_SH3        17
`define CDF_SH4        19

`define CDF_M0         2
`define CDF_M1         2
`define CDF_M2         3
`define CDF_M3         4
`define CDF_M4         14

`endif

// ==== logic/cdf_decim_chain.v ====
/*
 Complex half-band decimation chain: five decimate-by-two stages per path,
 I and Q each in their own cascade, plus a real bypass path.
 Assumes the mixer delivers I/Q and real samples synchronous to clk with a
 qualifying valid, and the downstream formatter takes every output strobe.
*/
`include "cdf_consts.vh"
`default_nettype none

module cdf_hb_stage #(
  parameter SID = 0,
  parameter DW  = `CDF_CPLX_W
) (
  input  wire                 clk,
  input  wire                 reset_n,
  input  wire                 in_vld,
  input  wire signed [DW-1:0] in_d,
  output reg                  out_vld_q,
  output reg  signed [DW-1:0] out_d_q
);
  localparam AW = `CDF_ACC_W;

  function integer hb_half;
    input integer s;
    begin
      case (s)
        0:       hb_half = `CDF_M0;
        1:       hb_half = `CDF_M1;
        2:       hb_half = `CDF_M2;
        3:       hb_half = `CDF_M3;
        default: hb_half = `CDF_M4;
      endcase
    end
  endfunction

  function integer hb_shift;
    input integer s;
    begin
      case (s)
        0:       hb_shift = `CDF_SH0;
        1:       hb_shift = `CDF_SH1;
        2:       hb_shift = `CDF_SH2;
        3:       hb_shift = `CDF_SH3;
        default: hb_shift = `CDF_SH4;
      endcase
    end
  endfunction

  // Nonzero taps only, outermost first; index M is the centre tap
  function integer hb_coef; // RULE5 RULE6
    input integer s;
    input integer j;
    begin
      case (s * 16 + j)
        0:  hb_coef = -1;      // RULE12
        1:  hb_coef = 9;
        2:  hb_coef = 16;
        16: hb_coef = -65;     // RULE13
        17: hb_coef = 577;
        18: hb_coef = 1024;
        32: hb_coef = 109;     // RULE14
        33: hb_coef = -837;
        34: hb_coef = 4824;
        35: hb_coef = 8192;
        48: hb_coef = -327;    // RULE15
        49: hb_coef = 2231;
        50: hb_coef = -8881;
        51: hb_coef = 39742;
        52: hb_coef = 65536;
        64: hb_coef = -37;     // RULE16
        65: hb_coef = 118;
        66: hb_coef = -291;
        67: hb_coef = 612;
        68: hb_coef = -1159;
        69: hb_coef = 2031;
        70: hb_coef = -3356;
        71: hb_coef = 5308;
        72: hb_coef = -8140;
        73: hb_coef = 12284;
        74: hb_coef = -18628;
        75: hb_coef = 29455;
        76: hb_coef = -53191;
        77: hb_coef = 166059;
        78: hb_coef = 262144;
        default: hb_coef = 0;
      endcase
    end
  endfunction

  localparam M  = hb_half(SID);
  localparam L  = 4 * M - 1;
  localparam CT = 2 * M - 1;
  localparam SH = hb_shift(SID);
  localparam signed [AW-1:0] MAXV = {{(AW-DW+1){1'b0}}, {(DW-1){1'b1}}};
  localparam signed [AW-1:0] MINV = ~MAXV;
  localparam signed [AW-1:0] HALF = {{(AW-1){1'b0}}, 1'b1} <<< (SH - 1);

  reg signed [DW-1:0] tap_q [0:L-1];
  reg                 ph_q;
  reg                 fire_q;
  integer             i;

  // Shift on each accepted sample; compute on every second one
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      for (i = 0; i < L; i = i + 1) begin
        tap_q[i] <= {DW{1'b0}};
      end
      ph_q   <= 1'b0;
      fire_q <= 1'b0;
    end else begin
      fire_q <= in_vld & ph_q; // RULE7
      if (in_vld) begin
        ph_q     <= ~ph_q;
        tap_q[0] <= in_d;
        for (i = 1; i < L; i = i + 1) begin
          tap_q[i] <= tap_q[i-1];
        end
      end
    end
  end

  reg signed [AW-1:0] shv;
  reg signed [DW-1:0] sd;

  // Sign-extend one tap to the accumulator width
  function signed [AW-1:0] widen;
    input signed [DW-1:0] v;
    begin
      widen = {{(AW-DW){v[DW-1]}}, v};
    end
  endfunction

  localparam signed [AW-1:0] CC = hb_coef(SID, M);

  // Folded sum: mirrored pairs share one multiplier, zero taps never built
  wire signed [AW-1:0] part [0:M];
  assign part[0] = CC * widen(tap_q[CT]);
  genvar g;
  generate
    for (g = 0; g < M; g = g + 1) begin : g_pair
      localparam signed [AW-1:0] CF = hb_coef(SID, g);
      wire signed [AW-1:0] pre;
      assign pre       = widen(tap_q[2*g]) + widen(tap_q[L-1-2*g]); // RULE11
      assign part[g+1] = part[g] + CF * pre; // RULE2
    end
  endgenerate

  always @* begin
    shv = (part[M] + HALF) >>> SH; // RULE7
    if (shv > MAXV) begin
      sd = MAXV[DW-1:0]; // RULE18
    end else if (shv < MINV) begin
      sd = MINV[DW-1:0]; // RULE18
    end else begin
      sd = shv[DW-1:0];
    end
  end

  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      out_vld_q <= 1'b0;
      out_d_q   <= {DW{1'b0}};
    end else begin
      out_vld_q <= fire_q;
      if (fire_q) begin
        out_d_q <= sd;
      end
    end
  end
endmodule // cdf_hb_stage

module cdf_decim_chain #(
  parameter DW = `CDF_CPLX_W,
  parameter RW = `CDF_REAL_W
) (
  input  wire                 clk,
  input  wire                 reset_n,
  input  wire [2:0]           decim_sel,
  input  wire                 in_valid,
  input  wire signed [DW-1:0] mix_i,
  input  wire signed [DW-1:0] mix_q,
  input  wire [RW-1:0]        real_in,
  output reg                  out_valid_q,
  output reg                  out_cplx_q,
  output reg  signed [DW-1:0] out_i_q,
  output reg  signed [DW-1:0] out_q_q,
  output reg  [RW-1:0]        out_real_q
);
  // Entry stage for each setting; later stages always follow in order
  function [2:0] first_stage;
    input [2:0] m;
    begin
      case (m)
        `CDF_MODE_D4:  first_stage = 3'h3; // RULE8
        `CDF_MODE_D8:  first_stage = 3'h2; // RULE8
        `CDF_MODE_D16: first_stage = 3'h1; // RULE9
        `CDF_MODE_D32: first_stage = 3'h0; // RULE10
        default:       first_stage = `CDF_NO_STAGE;
      endcase
    end
  endfunction

  // True where stage k takes mixer samples straight in
  function heads_cascade;
    input [2:0]   f;
    input integer k;
    begin
      heads_cascade = (f == k);
    end
  endfunction

  reg  [2:0]           mode_q;
  wire [2:0]           first;
  wire                 cplx;
  wire signed [DW-1:0] fin [0:1];
  wire                 fv  [0:1];
  wire                 strobe;

  assign first = first_stage(mode_q);
  assign cplx  = (first != `CDF_NO_STAGE);

  genvar p;
  genvar s;
  generate
    for (p = 0; p < 2; p = p + 1) begin : g_path
      // Same cascade for both paths keeps I and Q sample-aligned
      wire signed [DW-1:0] src;
      wire signed [DW-1:0] sd [0:`CDF_NSTAGE-1];
      wire                 sv [0:`CDF_NSTAGE-1];
      assign src = (p == 0) ? mix_i : mix_q; // RULE17
      for (s = 0; s < `CDF_NSTAGE; s = s + 1) begin : g_stg
        wire                 iv;
        wire signed [DW-1:0] id;
        if (s == 0) begin : g_head
          assign id = src;
          assign iv = in_valid & heads_cascade(first, s);
        end else begin : g_body
          assign id = heads_cascade(first, s) ? src : sd[s-1];
          assign iv = heads_cascade(first, s) ? in_valid : (sv[s-1] & (first < s));
        end
        cdf_hb_stage #(
          .SID (s),
          .DW  (DW)
        ) u_stage (
          .clk       (clk),
          .reset_n   (reset_n),
          .in_vld    (iv),
          .in_d      (id),
          .out_vld_q (sv[s]),
          .out_d_q   (sd[s])
        ); // RULE1
      end
      assign fin[p] = sd[`CDF_LAST_STAGE];
      assign fv[p]  = sv[`CDF_LAST_STAGE] & cplx;
    end
  endgenerate

  // Both paths must agree; they share every strobe by construction
  assign strobe = fv[0] & fv[1]; // RULE17

  // Output register; stage widths are already DW so no extra clip needed
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      mode_q      <= `CDF_MODE_BYP;
      out_valid_q <= 1'b0;
      out_cplx_q  <= 1'b0;
      out_i_q     <= {DW{1'b0}};
      out_q_q     <= {DW{1'b0}};
      out_real_q  <= {RW{1'b0}};
    end else begin
      mode_q     <= decim_sel;
      out_cplx_q <= cplx;
      if (!cplx) begin
        out_valid_q <= in_valid; // RULE3
        if (in_valid) begin
          out_real_q <= real_in; // RULE3
        end
      end else begin
        out_valid_q <= strobe; // RULE4
        if (strobe) begin
          out_i_q <= fin[0]; // RULE1
          out_q_q <= fin[1]; // RULE18
        end
      end
    end
  end
endmodule // cdf_decim_chain

`default_nettype wire

// ==== tb/cdf_chain_props.sv ====
/* Port checker for the decimation chain.
 Assumes one clock and an async active-low reset; bound below. */
`default_nettype none
module cdf_chain_props (
  input wire logic               clk,
  input wire logic               reset_n,
  input wire logic [2:0]         decim_sel,
  input wire logic               in_valid,
  input wire logic [11:0]        real_in,
  input wire logic               out_valid_q,
  input wire logic               out_cplx_q,
  input wire logic signed [14:0] out_i_q,
  input wire logic signed [14:0] out_q_q,
  input wire logic [11:0]        out_real_q
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clk);
  endclocking
  default disable iff (!reset_n);
  // Three samples of bypass: a strobe lags the mode pin by two edges
  sequence s_byp;
    decim_sel == 3'h0 && $past(decim_sel) == 3'h0 && $past(decim_sel, 2) == 3'h0;
  endsequence
  sequence s_idle;
    (!in_valid) [*8];
  endsequence
  property p_byp_pass;
    s_byp ##0 in_valid |=> out_valid_q && out_real_q == $past(real_in);
  endproperty
  property p_byp_idle;
    s_byp ##0 !in_valid |=> !out_valid_q;
  endproperty
  property p_byp_src;
    s_byp ##0 out_valid_q |-> $past(in_valid);
  endproperty
  property p_cplx_lvl;
    $stable(decim_sel) [*3] |-> out_cplx_q == (decim_sel inside {[3'h1:3'h4]});
  endproperty
  // Fastest decimating setting is four, so a strobe is never closer
  property p_dec_gap;
    out_valid_q && out_cplx_q && decim_sel inside {[3'h1:3'h4]}
      |=> (!(out_valid_q && out_cplx_q)) [*3];
  endproperty
  property p_iq_hold;
    !out_valid_q |-> $stable(out_i_q) && $stable(out_q_q);
  endproperty
  property p_real_hold;
    !out_valid_q |-> $stable(out_real_q);
  endproperty
  property p_quiet;
    s_idle ##1 s_idle |=> !out_valid_q;
  endproperty
  a_byp_pass: assert property (p_byp_pass) else $error("bypass sample lost");
  a_byp_idle: assert property (p_byp_idle) else $error("bypass strobe unasked");
  a_byp_src: assert property (p_byp_src) else $error("bypass strobe w/o input");
  a_cplx_lvl: assert property (p_cplx_lvl) else $error("complex flag wrong");
  a_dec_gap: assert property (p_dec_gap) else $error("strobes too close");
  a_iq_hold: assert property (p_iq_hold) else $error("I/Q moved w/o strobe");
  a_real_hold: assert property (p_real_hold) else $error("real moved w/o strobe");
  a_quiet: assert property (p_quiet) else $error("strobe after long idle");
endmodule // cdf_chain_props
bind cdf_decim_chain cdf_chain_props u_cdf_chain_props (.clk(clk), .reset_n(reset_n),
  .decim_sel(decim_sel), .in_valid(in_valid), .real_in(real_in), .out_valid_q(out_valid_q),
  .out_cplx_q(out_cplx_q), .out_i_q(out_i_q), .out_q_q(out_q_q), .out_real_q(out_real_q));
`default_nettype wire

// ==== tb/cdf_decim_chain_tb.sv ====
/* Self-checking bench for the decimation chain.
 Assumes the chain and its sink model; DC levels give exact expectations. */
`include "cdf_consts.vh"
`default_nettype none
module cdf_decim_chain_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 0, reset_n = 0, in_valid = 0, clr = 0;
  logic [2:0] decim_sel = 3'h0;
  logic signed [14:0] mix_i = 0, mix_q = 0;
  logic [11:0] real_in = 0;
  logic [31:0] seed = 32'h0558;
  wire out_valid_q, out_cplx_q;
  wire signed [14:0] out_i_q, out_q_q;
  wire [11:0] out_real_q;
  int fail_count = 0, n_tests = 0, n_strobe;
  cdf_decim_chain u_cdf_decim_chain (.clk(clk), .reset_n(reset_n), .decim_sel(decim_sel),
    .in_valid(in_valid), .mix_i(mix_i), .mix_q(mix_q), .real_in(real_in),
    .out_valid_q(out_valid_q), .out_cplx_q(out_cplx_q), .out_i_q(out_i_q),
    .out_q_q(out_q_q), .out_real_q(out_real_q));
  cdf_sink u_cdf_sink (.clk(clk), .clr(clr), .out_valid_q(out_valid_q), .n_strobe(n_strobe));
  initial forever #25 clk = ~clk;
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction
  // Settled DC through stages 4-m..4; tap sums are each stage's DC gain
  function automatic logic signed [14:0] dc_out(input int m, input int x);
    longint g[5] = '{32, 2048, 16384, 131066, 524274};
    int sh[5] = '{`CDF_SH0, `CDF_SH1, `CDF_SH2, `CDF_SH3, `CDF_SH4};
    longint a;
    for (int k = 4 - m; k < 5; k++) begin
      a = (g[k] * x + (longint'(1) << (sh[k] - 1))) >>> sh[k];
      x = a > 16383 ? 16383 : (a < -16384 ? -16384 : int'(a));
    end
    return x[14:0];
  endfunction
  task automatic chk(input string what, input logic [31:0] e, input logic [31:0] s);
    n_tests++;
    if (e !== s) begin
      fail_count++;
      $display("mismatch %s expected %0h seen %0h", what, e, s);
    end
  endtask
  task automatic step(input logic v, input logic [14:0] i, q, input logic [11:0] r);
    @(posedge clk);
    #2;
    in_valid = v;
    mix_i = i;
    mix_q = q;
    real_in = r;
  endtask
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    #1000000;
    fail_count++;
    report_and_stop();
  end
  initial begin
    logic signed [14:0] a, b;
    logic pv;
    logic [11:0] pr;
    repeat (10) @(posedge clk);
    #2;
    reset_n = 1;
    for (int n = 0; n < 400; n++) begin
      seed = xs(seed);
      pv = in_valid;
      pr = real_in;
      decim_sel = n < 200 ? 3'h0 : 3'h7;
      step(seed[0], seed[26:12], seed[14:0], seed[31:20]);
      chk("byp_valid", pv, out_valid_q);
      if (pv) chk("byp_real", pr, out_real_q);
      chk("byp_cplx", 0, out_cplx_q);
    end
    $display("test bypass done");
    // Full scale last: only the tap-sum shortfall keeps it off the rails
    for (int m = 1; m < 5; m++) begin
      seed = xs(seed);
      a = m == 4 ? 15'h3fff : seed[14:0];
      b = m == 4 ? 15'h4000 : seed[30:16];
      decim_sel = 3'(m);
      repeat (2000) step(1, a, b, seed[11:0]);
      clr = 1;
      step(1, a, b, seed[11:0]);
      clr = 0;
      repeat (256) step(1, a, b, seed[11:0]);
      chk("strobes", 256 >> (m + 1), n_strobe);
      chk("cplx", 1, out_cplx_q);
      chk("out_i", dc_out(m, a), out_i_q);
      chk("out_q", dc_out(m, b), out_q_q);
      repeat (20) step(0, a, b, seed[11:0]);
      $display("test decimate mode %0d done", m);
    end
    report_and_stop();
  end
endmodule // cdf_decim_chain_tb
`default_nettype wire

// ==== tb/cdf_sink.sv ====
/* Downstream formatter model: takes every strobe, counts them.
 Assumes no back-pressure; clr is driven off the clock edge. */
`default_nettype none
module cdf_sink (
  input wire logic clk,
  input wire logic clr,
  input wire logic out_valid_q,
  output var int   n_strobe
);
  timeunit 1ns;
  timeprecision 1ns;
  always @(posedge clk) begin
    if (clr) n_strobe <= 0;
    else if (out_valid_q) n_strobe <= n_strobe + 1;
  end
endmodule // cdf_sink
`default_nettype wire
